// file: design/orwg_guard.sv
// on-chip ram write guard: three page allow bits gate writes to the ram
`timescale 1ns/1ps
`default_nettype none
module orwg_guard
   import orwg_pkg::*;
#(
   parameter bit SMALL_VARIANT = 1'b0
)
(
   input  wire logic               clk,
   input  wire logic               arst_n,
   input  wire orwg_pkg::orwg_req_t cpu_req,
   output orwg_pkg::orwg_rsp_t     cpu_rsp,
   input  wire logic               allow_wr,
   input  wire logic [2:0]         allow_wdata,
   output logic [2:0]              allow_rdata,
   output logic                    ram_we,
   output logic [31:0]             ram_addr,
   output logic [31:0]             ram_wdata,
   output logic [3:0]              ram_be,
   output logic                    ram_re,
   input  wire logic [31:0]        ram_rdata,
   output logic                    write_blocked
);
   import orwg_pkg::*;

   localparam logic [31:0] PAGE1_LAST = SMALL_VARIANT ? ORWG_PAGE1_LAST_SML
                                                      : ORWG_PAGE1_LAST_BIG;

   typedef enum logic [1:0]
   {
      ORWG_IDLE  = 2'b00,
      ORWG_RDATA = 2'b01
   } orwg_state_t;

   // ************************************************************
   // allow bits
   // ************************************************************
   logic [2:0]  allow_reg;
   logic [2:0]  hit;
   logic [2:0]  blk;
   logic        any_hit;
   logic        is_blocked;
   orwg_state_t state_reg;

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         allow_reg <= ORWG_ALLOW_RESET;
      else if (allow_wr)
         allow_reg <= allow_wdata;
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         allow_rdata <= ORWG_ALLOW_RESET;
      else
         allow_rdata <= allow_reg;
   end

   // ************************************************************
   // page decode
   // ************************************************************
   orwg_range #(.BASE(ORWG_PAGE0_BASE), .LAST(ORWG_PAGE0_LAST)) u_page0
   (
      .addr    (cpu_req.addr),
      .allow   (allow_reg[ORWG_PAGE0_BIT]),
      .hit     (hit[0]),
      .blocked (blk[0])
   );
   orwg_range #(.BASE(ORWG_PAGE1_BASE), .LAST(PAGE1_LAST)) u_page1
   (
      .addr    (cpu_req.addr),
      .allow   (allow_reg[ORWG_PAGE1_BIT]),
      .hit     (hit[1]),
      .blocked (blk[1])
   );
   orwg_range #(.BASE(ORWG_PAGE2_BASE), .LAST(ORWG_PAGE2_LAST)) u_page2
   (
      .addr    (cpu_req.addr),
      .allow   (allow_reg[ORWG_PAGE2_BIT]),
      .hit     (hit[2]),
      .blocked (blk[2])
   );

   assign any_hit    = |hit;
   assign is_blocked = |blk;

   // ************************************************************
   // ram strobes, one cycle after the request
   // ************************************************************
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ram_we    <= 1'b0;
         ram_re    <= 1'b0;
         ram_addr  <= 32'h00000000;
         ram_wdata <= 32'h00000000;
         ram_be    <= 4'h0;
      end
      else
      begin
         ram_we    <= cpu_req.valid && cpu_req.write && any_hit && !is_blocked;
         ram_re    <= cpu_req.valid && !cpu_req.write && any_hit;
         ram_addr  <= cpu_req.addr;
         ram_wdata <= cpu_req.wdata;
         ram_be    <= cpu_req.be;
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         write_blocked <= 1'b0;
      else
         write_blocked <= cpu_req.valid && cpu_req.write && is_blocked;
   end

   // ************************************************************
   // answer: writes one cycle, reads two
   // ************************************************************
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         state_reg <= ORWG_IDLE;
      else
      begin
         case (state_reg)
            ORWG_IDLE:
               if (cpu_req.valid && !cpu_req.write)
                  state_reg <= ORWG_RDATA;
            ORWG_RDATA:
               state_reg <= ORWG_IDLE;
            default:
               state_reg <= ORWG_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         cpu_rsp <= '0;
      else
      begin
         cpu_rsp.err <= 1'b0;
         case (state_reg)
            ORWG_IDLE:
            begin
               cpu_rsp.done  <= cpu_req.valid && cpu_req.write;
               cpu_rsp.rdata <= 32'h00000000;
            end
            ORWG_RDATA:
            begin
               cpu_rsp.done  <= 1'b1;
               cpu_rsp.rdata <= ram_rdata;
            end
            default:
            begin
               cpu_rsp.done  <= 1'b0;
               cpu_rsp.rdata <= 32'h00000000;
            end
         endcase
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   AST_P0_BLOCK: assert property (@(posedge clk) disable iff (!arst_n)
      (cpu_req.valid && cpu_req.write && cpu_req.addr >= ORWG_PAGE0_BASE
       && cpu_req.addr <= ORWG_PAGE0_LAST && !allow_reg[0]) |=> !ram_we)
      else $error("page0 write passed while blocked");
   AST_P1_BLOCK: assert property (@(posedge clk) disable iff (!arst_n)
      (cpu_req.valid && cpu_req.write && cpu_req.addr >= ORWG_PAGE1_BASE
       && cpu_req.addr <= PAGE1_LAST && !allow_reg[1]) |=> !ram_we)
      else $error("page1 write passed while blocked");
   AST_P2_BLOCK: assert property (@(posedge clk) disable iff (!arst_n)
      (cpu_req.valid && cpu_req.write && cpu_req.addr >= ORWG_PAGE2_BASE
       && cpu_req.addr <= ORWG_PAGE2_LAST && !allow_reg[2]) |=> !ram_we)
      else $error("page2 write passed while blocked");
   AST_ALLOW_PASS: assert property (@(posedge clk) disable iff (!arst_n)
      (cpu_req.valid && cpu_req.write && any_hit && !is_blocked) |=>
      (ram_we && ram_addr == $past(cpu_req.addr)))
      else $error("allowed write not passed");
   AST_ALLOW_STORE: assert property (@(posedge clk) disable iff (!arst_n)
      allow_wr |=> (allow_reg == $past(allow_wdata)) ##1 (allow_rdata == $past(allow_wdata, 2)))
      else $error("allow bits not stored");
   AST_NO_WE_OFF: assert property (@(posedge clk) disable iff (!arst_n)
      ram_we |-> $past(cpu_req.valid && cpu_req.write && any_hit && !is_blocked))
      else $error("ram write without allowed request");
   AST_BLK_DONE: assert property (@(posedge clk) disable iff (!arst_n)
      (cpu_req.valid && cpu_req.write && is_blocked) |=>
      (cpu_rsp.done && !cpu_rsp.err && write_blocked && !ram_we))
      else $error("blocked write not completed quietly");
   AST_READ_OK: assert property (@(posedge clk) disable iff (!arst_n)
      (state_reg == ORWG_IDLE && cpu_req.valid && !cpu_req.write && any_hit) |=>
      ram_re ##1 (cpu_rsp.done && !cpu_rsp.err))
      else $error("read disturbed");

   COV_BLOCKED: cover property (@(posedge clk) disable iff (!arst_n) write_blocked);
   COV_WRITE:   cover property (@(posedge clk) disable iff (!arst_n) ram_we);
   COV_READ:    cover property (@(posedge clk) disable iff (!arst_n) ram_re ##1 cpu_rsp.done);
endmodule
`default_nettype wire

// file: design/orwg_pkg.sv
// package: address map, reset values and carriers for the ram write guard
package orwg_pkg;
   // ************************************************************
   // page address ranges
   // ************************************************************
   localparam logic [31:0] ORWG_PAGE0_BASE      = 32'hFFF80000;
   localparam logic [31:0] ORWG_PAGE0_LAST      = 32'hFFF81FFF;
   localparam logic [31:0] ORWG_PAGE1_BASE      = 32'hFFF82000;
   localparam logic [31:0] ORWG_PAGE1_LAST_BIG  = 32'hFFF83FFF;
   localparam logic [31:0] ORWG_PAGE1_LAST_SML  = 32'hFFF82FFF;
   localparam logic [31:0] ORWG_PAGE2_BASE      = 32'hFFF84000;
   localparam logic [31:0] ORWG_PAGE2_LAST      = 32'hFFF85FFF;
   // ************************************************************
   // enable bits
   // ************************************************************
   localparam int          ORWG_PAGES           = 3;
   localparam int          ORWG_PAGE0_BIT       = 0;
   localparam int          ORWG_PAGE1_BIT       = 1;
   localparam int          ORWG_PAGE2_BIT       = 2;
   localparam logic [2:0]  ORWG_ALLOW_RESET     = 3'h7;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [31:0] addr;
      logic [31:0] wdata;
      logic [3:0]  be;
   } orwg_req_t;

   typedef struct packed {
      logic        done;
      logic        err;
      logic [31:0] rdata;
   } orwg_rsp_t;
endpackage

// file: design/orwg_range.sv
// one page address window compare with its allow bit
`timescale 1ns/1ps
`default_nettype none
module orwg_range
#(
   parameter logic [31:0] BASE = 32'h00000000,
   parameter logic [31:0] LAST = 32'h00000000
)
(
   input  wire logic [31:0] addr,
   input  wire logic        allow,
   output logic             hit,
   output logic             blocked
);
   assign hit     = (addr >= BASE) && (addr <= LAST);
   assign blocked = hit && !allow;
endmodule
`default_nettype wire

// file: verification/orwg_guard_test.sv
// self-checking bench for the ram write guard
`timescale 1ns/1ps
`default_nettype none
module orwg_guard_test;
   import orwg_pkg::*;
   logic        clk         = 1'b0;
   logic        arst_n      = 1'b0;
   orwg_req_t   cpu_req     = '0;
   orwg_rsp_t   cpu_rsp;
   logic        allow_wr    = 1'b0;
   logic [2:0]  allow_wdata = 3'h7;
   logic [2:0]  allow_rdata;
   logic        ram_we;
   logic        ram_re;
   logic        write_blocked;
   logic [31:0] ram_addr;
   logic [31:0] ram_wdata;
   logic [31:0] ram_rdata;
   logic [3:0]  ram_be;
   orwg_rsp_t   small_rsp;
   logic [2:0]  small_allow;
   logic [2:0]  small_rdata;
   logic        small_we;
   logic        small_blocked;
   logic [31:0] pg_base [0:2] = '{ORWG_PAGE0_BASE, ORWG_PAGE1_BASE, ORWG_PAGE2_BASE};
   logic [31:0] pg_last [0:2] = '{ORWG_PAGE0_LAST, ORWG_PAGE1_LAST_BIG, ORWG_PAGE2_LAST};
   int          bad_count   = 0;
   int          num_checks  = 0;

   orwg_guard dut_u (.clk(clk), .arst_n(arst_n), .cpu_req(cpu_req), .cpu_rsp(cpu_rsp),
      .allow_wr(allow_wr), .allow_wdata(allow_wdata), .allow_rdata(allow_rdata),
      .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_be(ram_be),
      .ram_re(ram_re), .ram_rdata(ram_rdata), .write_blocked(write_blocked));
   orwg_ram_model ram_u (.clk(clk), .ram_we(ram_we), .ram_addr(ram_addr),
      .ram_wdata(ram_wdata), .ram_be(ram_be), .ram_re(ram_re), .ram_rdata(ram_rdata));
   // small variant: software keeps page2 allow set
   orwg_guard #(.SMALL_VARIANT(1'b1)) small_u (.clk(clk), .arst_n(arst_n), .cpu_req(cpu_req),
      .cpu_rsp(small_rsp), .allow_wr(allow_wr), .allow_wdata(small_allow),
      .allow_rdata(small_rdata), .ram_we(small_we), .ram_addr(), .ram_wdata(), .ram_be(),
      .ram_re(), .ram_rdata(ram_rdata), .write_blocked(small_blocked));
   assign small_allow = allow_wdata | 3'h4;

   always #2.5 clk = ~clk;

   // ************************************************************
   // shared tasks
   // ************************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic close_out;
      if (bad_count == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic do_write(input logic [31:0] a, input logic [31:0] d, input logic ok,
                           input logic inpage);
      @(posedge clk);
      cpu_req <= '{1'b1, 1'b1, a, d, 4'hF};
      @(posedge clk);
      cpu_req.valid <= 1'b0;
      #1;
      check(cpu_rsp.done, 1'b1);
      check(cpu_rsp.err, 1'b0);
      check(ram_we, ok);
      check(write_blocked, inpage & !ok);
      check(ram_addr, a);
      check(ram_wdata, d);
      check(ram_be, 4'hF);
   endtask

   task automatic do_read(input logic [31:0] a, input logic [31:0] exp);
      @(posedge clk);
      cpu_req <= '{1'b1, 1'b0, a, 32'h00000000, 4'hF};
      @(posedge clk);
      cpu_req.valid <= 1'b0;
      #1;
      check(ram_re, 1'b1);
      @(posedge clk);
      #1;
      check(cpu_rsp.done, 1'b1);
      check(cpu_rsp.rdata, exp);
   endtask

   task automatic set_allow(input logic [2:0] v);
      @(posedge clk);
      allow_wr <= 1'b1;
      allow_wdata <= v;
      @(posedge clk);
      allow_wr <= 1'b0;
      @(posedge clk);
      #1;
      check(allow_rdata, v);
   endtask

   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic sc_reset;
      #1;
      check(allow_rdata, 3'h7);
      check(cpu_rsp.done, 1'b0);
      check(cpu_rsp.rdata, 32'h00000000);
      check(ram_we, 1'b0);
      check(write_blocked, 1'b0);
   endtask

   task automatic sc_pages;
      int q;
      for (int p = 0; p < 3; p++)
      begin
         q = (p + 1) % 3;
         set_allow(3'h7);
         do_write(pg_base[p], 32'hA5A50000 + 32'(p), 1'b1, 1'b1);
         do_write(pg_last[p], 32'h5A5A0000 + 32'(p), 1'b1, 1'b1);
         do_read(pg_base[p], 32'hA5A50000 + 32'(p));
         set_allow(3'h7 & ~(3'h1 << p));
         do_write(pg_base[p], 32'h0F0F0F0F, 1'b0, 1'b1);
         do_write(pg_last[p], 32'hF0F0F0F0, 1'b0, 1'b1);
         do_read(pg_base[p], 32'hA5A50000 + 32'(p));
         do_read(pg_last[p], 32'h5A5A0000 + 32'(p));
         do_write(pg_base[q], 32'h3C3C0000 + 32'(q), 1'b1, 1'b1);
         do_read(pg_base[q], 32'h3C3C0000 + 32'(q));
      end
   endtask

   task automatic sc_outside;
      set_allow(3'h0);
      do_write(32'hFFF7FFFC, 32'h11111111, 1'b0, 1'b0);
      do_write(32'hFFF86000, 32'h22222222, 1'b0, 1'b0);
      set_allow(3'h7);
      do_write(32'hFFF7FFFC, 32'h33333333, 1'b0, 1'b0);
      do_write(32'hFFF86000, 32'h44444444, 1'b0, 1'b0);
   endtask

   task automatic sc_small;
      set_allow(3'h0);
      check(small_rdata, 3'h4);
      do_write(32'hFFF82FFC, 32'h12340000, 1'b0, 1'b1);
      check(small_blocked, 1'b1);
      check(small_we, 1'b0);
      check(small_rsp.done, 1'b1);
      do_write(32'hFFF83000, 32'h12340001, 1'b0, 1'b1);
      check(small_blocked, 1'b0);
      do_write(pg_base[2], 32'h12340002, 1'b0, 1'b1);
      check(small_we, 1'b1);
      check(small_blocked, 1'b0);
      set_allow(3'h2);
      check(small_rdata, 3'h6);
      do_write(32'hFFF83000, 32'h12340003, 1'b1, 1'b1);
      check(small_we, 1'b0);
      set_allow(3'h7);
   endtask

   task automatic sc_midreset;
      set_allow(3'h0);
      @(posedge clk);
      arst_n <= 1'b0;
      repeat (2) @(posedge clk);
      sc_reset();
      @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      sc_reset();
      do_write(pg_base[0], 32'h77770000, 1'b1, 1'b1);
      do_read(pg_base[0], 32'h77770000);
   endtask

   initial
   begin
      repeat (15) @(posedge clk);
      sc_reset();
      @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      sc_reset();
      sc_pages();
      sc_outside();
      sc_small();
      sc_midreset();
      close_out();
   end

   initial
   begin
      #100000;
      bad_count++;
      close_out();
   end
endmodule
`default_nettype wire

// file: verification/orwg_ram_model.sv
// ram array model standing behind the write guard
`timescale 1ns/1ps
`default_nettype none
module orwg_ram_model
(
   input  wire logic        clk,
   input  wire logic        ram_we,
   input  wire logic [31:0] ram_addr,
   input  wire logic [31:0] ram_wdata,
   input  wire logic [3:0]  ram_be,
   input  wire logic        ram_re,
   output logic [31:0]      ram_rdata
);
   logic [31:0] mem [0:8191];
   logic [31:0] last_reg;

   always_ff @(posedge clk)
   begin
      if (ram_we)
      begin
         for (int i = 0; i < 4; i++)
            if (ram_be[i])
               mem[ram_addr[14:2]][8*i +: 8] <= ram_wdata[8*i +: 8];
      end
      if (ram_re)
         last_reg <= mem[ram_addr[14:2]];
   end

   // idle data lines show the inverse of the last word read
   assign ram_rdata = ram_re ? mem[ram_addr[14:2]] : ~last_reg;
endmodule
`default_nettype wire
